// ==== design/host_interface_select_cfg.svh ====
// Constants for the host interface selection front end
//
// Functional notes
// - Strap to ground selects four-wire SPI; 56k selects three-wire SPI; no address.
// - A 68k strap selects the two-wire clocked link only, without a slave address.
// - SMBus straps 82k,100k,120k,150k,supply give addresses 0x2C,0x2B,0x2A,0x29,0x28.
// - SMBus accepts send, receive, read and write byte plus block transfers.
// - Block transfers carry no count byte; any number of consecutive bytes.
// - In SMBus or two-wire modes the SPI chip select is ignored entirely.
// - SPI supports three-wire and four-wire variants, only while chip select is low.
// - The two-wire link supports only single-register read byte and write byte.
// - After power-up, host transactions are ignored for 15 ms.
// - Register-side behaviour is identical whichever transport is selected.
// - The SMBus address byte is seven address bits then a direction bit.
// - An SMBus stop condition returns the client interface to idle.
// - SPI moves 8-bit packets latched on rising clock; clock and data idle high.
`ifndef HOST_INTERFACE_SELECT_CFG_SVH
`define HOST_INTERFACE_SELECT_CFG_SVH

// Strap codes from the select pin comparator
`define STRAP_GND 3'h0
`define STRAP_56K 3'h1
`define STRAP_68K 3'h2
`define STRAP_82K 3'h3
`define STRAP_100K 3'h4
`define STRAP_120K 3'h5
`define STRAP_150K 3'h6
`define STRAP_VDD 3'h7

// Seven-bit slave addresses per strap
`define ADDR_82K 7'h2c
`define ADDR_100K 7'h2b
`define ADDR_120K 7'h2a
`define ADDR_150K 7'h29
`define ADDR_VDD 7'h28

// Timing
`define CLK_HZ 40000000
`define QUIET_MS 15
`define QUIET_CYC ((`QUIET_MS * `CLK_HZ) / 1000)
`define STRAP_SETTLE 3
`define BYTE_BITS 8

`endif

// ==== design/host_select_pkg.sv ====
// Types shared by the host interface selection front end
`default_nettype none
package host_select_pkg;

    typedef enum logic [1:0] {
        MODE_SPI4 = 2'b00,
        MODE_SPI3 = 2'b01,
        MODE_SMBUS = 2'b10,
        MODE_TWO_WIRE = 2'b11
    } hostMode_t;

    typedef struct packed {
        hostMode_t mode;
        logic hasAddr;
        logic [6:0] slaveAddr;
    } hostSel_t;

    typedef struct packed {
        logic first;
        logic [7:0] data;
    } byteBeat_t;

    typedef enum logic [2:0] {
        SMB_IDLE = 3'b000,
        SMB_ADDR = 3'b001,
        SMB_ADDR_ACK = 3'b011,
        SMB_WR_BYTE = 3'b010,
        SMB_WR_ACK = 3'b110,
        SMB_RD_BYTE = 3'b111,
        SMB_RD_ACK = 3'b101,
        SMB_WAIT = 3'b100
    } smbState_t;

endpackage
`default_nettype wire

// ==== design/host_interface_select.sv ====
// Host interface selection, SMBus client and SPI receive front end
`timescale 1ns/1ps
`default_nettype none
`include "host_interface_select_cfg.svh"

module host_interface_select import host_select_pkg::*; #(
    parameter int QUIET_CYCLES = `QUIET_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] strapCode,
    input wire logic spiClk,
    input wire logic spiCsN,
    input wire logic spiMosi,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    input wire logic [7:0] txByte,
    output logic txReq,
    output hostSel_t sel,
    output logic ready,
    output logic blockEnable,
    output logic twoWireSel,
    output logic rxValid,
    output byteBeat_t rxBeat
);

    localparam int QW = $clog2(QUIET_CYCLES + 1);

    // Strap decode table
    function automatic hostSel_t decodeStrap(input logic [2:0] code);
        hostSel_t s;
        s = '{mode: MODE_SMBUS, hasAddr: 1'b1, slaveAddr: `ADDR_VDD};
        case (code)
            `STRAP_GND: s = '{mode: MODE_SPI4, hasAddr: 1'b0, slaveAddr: 7'h00};
            `STRAP_56K: s = '{mode: MODE_SPI3, hasAddr: 1'b0, slaveAddr: 7'h00};
            `STRAP_68K: s = '{mode: MODE_TWO_WIRE, hasAddr: 1'b0, slaveAddr: 7'h00};
            `STRAP_82K: s.slaveAddr = `ADDR_82K;
            `STRAP_100K: s.slaveAddr = `ADDR_100K;
            `STRAP_120K: s.slaveAddr = `ADDR_120K;
            `STRAP_150K: s.slaveAddr = `ADDR_150K;
            default: s.slaveAddr = `ADDR_VDD;
        endcase
        return s;
    endfunction

    logic [2:0] strapS1;
    logic [2:0] strapS2;
    logic [QW-1:0] quietCnt;
    logic captured;

    // Strap pin synchroniser
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strapS1 <= 3'h0;
            strapS2 <= 3'h0;
        end else begin
            strapS1 <= strapCode;
            strapS2 <= strapS1;
        end
    end

    // Quiet period after reset, strap captured once early in it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            quietCnt <= '0;
            ready <= 1'b0;
            captured <= 1'b0;
            sel <= '{mode: MODE_SPI4, hasAddr: 1'b0, slaveAddr: 7'h00};
        end else begin
            if (!ready) begin
                quietCnt <= quietCnt + QW'(1);
                ready <= (quietCnt == QW'(QUIET_CYCLES - 1));
            end
            if (!captured && quietCnt == QW'(`STRAP_SETTLE)) begin
                sel <= decodeStrap(strapS2);
                captured <= 1'b1;
            end
        end
    end

    logic smbOn;
    logic spiOn;
    assign smbOn = ready && sel.mode == MODE_SMBUS;
    assign spiOn = ready && (sel.mode == MODE_SPI4 || sel.mode == MODE_SPI3);
    assign blockEnable = sel.mode == MODE_SMBUS;
    assign twoWireSel = ready && sel.mode == MODE_TWO_WIRE;

    // Link clock domain: SPI shifter, cleared whenever chip select is high
    logic linkRst_n;
    logic [2:0] spiBits;
    logic [7:0] sh4;
    logic [7:0] sh3;
    logic gotOne;
    logic [7:0] spiByte4;
    logic [7:0] spiByte3;
    logic spiFirstL;
    logic spiTgl;
    assign linkRst_n = rst_n & ~spiCsN;

    // Shift on rising clock edges while selected
    always_ff @(posedge spiClk or negedge linkRst_n) begin
        if (!linkRst_n) begin
            spiBits <= 3'h0;
            sh4 <= 8'h00;
            sh3 <= 8'h00;
            gotOne <= 1'b0;
        end else begin
            spiBits <= spiBits + 3'h1;
            sh4 <= {sh4[6:0], spiMosi};
            sh3 <= {sh3[6:0], sdaIn};
            if (spiBits == 3'h7) begin
                gotOne <= 1'b1;
            end
        end
    end

    // Completed bytes held past chip select release, announced by a toggle
    always_ff @(posedge spiClk or negedge rst_n) begin
        if (!rst_n) begin
            spiByte4 <= 8'h00;
            spiByte3 <= 8'h00;
            spiFirstL <= 1'b0;
            spiTgl <= 1'b0;
        end else if (spiBits == 3'h7 && !spiCsN) begin
            spiByte4 <= {sh4[6:0], spiMosi};
            spiByte3 <= {sh3[6:0], sdaIn};
            spiFirstL <= !gotOne;
            spiTgl <= !spiTgl;
        end
    end

    // Toggle crossing into the core clock
    logic tglS1;
    logic tglS2;
    logic tglD;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tglS1 <= 1'b0;
            tglS2 <= 1'b0;
            tglD <= 1'b0;
        end else begin
            tglS1 <= spiTgl;
            tglS2 <= tglS1;
            tglD <= tglS2;
        end
    end

    logic spiEvent;
    logic spiValid;
    logic [7:0] spiData;
    assign spiEvent = tglS2 ^ tglD;
    assign spiValid = spiEvent && spiOn;
    assign spiData = (sel.mode == MODE_SPI3) ? spiByte3 : spiByte4;

    // SMBus pin synchronisers
    logic sclS1;
    logic sclS2;
    logic sclD;
    logic sdaS1;
    logic sdaS2;
    logic sdaD;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {sclS1, sclS2, sclD} <= 3'h7;
            {sdaS1, sdaS2, sdaD} <= 3'h7;
        end else begin
            {sclS1, sclS2, sclD} <= {sclIn, sclS1, sclS2};
            {sdaS1, sdaS2, sdaD} <= {sdaIn, sdaS1, sdaS2};
        end
    end

    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    assign sclRise = sclS2 && !sclD;
    assign sclFall = !sclS2 && sclD;
    assign startCond = sclS2 && sclD && sdaD && !sdaS2;
    assign stopCond = sclS2 && sclD && !sdaD && sdaS2;

    smbState_t state;
    logic [3:0] bitCnt;
    logic [7:0] shifter;
    logic rw;
    logic drive;
    logic masterAck;
    logic firstByte;
    logic smbValid;
    logic [7:0] smbData;
    logic smbFirst;

    // SMBus client sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= SMB_IDLE;
            bitCnt <= 4'h0;
            shifter <= 8'h00;
            {rw, drive, masterAck, firstByte, smbValid, smbFirst, txReq} <= 7'h00;
            smbData <= 8'h00;
        end else begin
            smbValid <= 1'b0;
            txReq <= 1'b0;
            if (!smbOn || stopCond) begin
                state <= SMB_IDLE;
                drive <= 1'b0;
            end else if (startCond) begin
                state <= SMB_ADDR;
                bitCnt <= 4'h0;
                drive <= 1'b0;
            end else begin
                case (state)
                    SMB_ADDR, SMB_WR_BYTE: begin
                        if (sclRise) begin
                            shifter <= {shifter[6:0], sdaS2};
                            bitCnt <= bitCnt + 4'h1;
                        end else if (sclFall && bitCnt == 4'h8 && state == SMB_ADDR) begin
                            if (shifter[7:1] == sel.slaveAddr) begin
                                state <= SMB_ADDR_ACK;
                                drive <= 1'b1;
                                rw <= shifter[0];
                                txReq <= shifter[0];
                            end else begin
                                state <= SMB_WAIT;
                            end
                        end else if (sclFall && bitCnt == 4'h8) begin
                            state <= SMB_WR_ACK;
                            drive <= 1'b1;
                            smbValid <= 1'b1;
                            smbData <= shifter;
                            smbFirst <= firstByte;
                            firstByte <= 1'b0;
                        end
                    end
                    SMB_ADDR_ACK: begin
                        if (sclFall) begin
                            bitCnt <= 4'h0;
                            firstByte <= 1'b1;
                            state <= rw ? SMB_RD_BYTE : SMB_WR_BYTE;
                            shifter <= txByte;
                            drive <= rw && !txByte[7];
                        end
                    end
                    SMB_WR_ACK: begin
                        if (sclFall) begin
                            state <= SMB_WR_BYTE;
                            drive <= 1'b0;
                            bitCnt <= 4'h0;
                        end
                    end
                    SMB_RD_BYTE: begin
                        if (sclRise) begin
                            bitCnt <= bitCnt + 4'h1;
                        end else if (sclFall && bitCnt == 4'h8) begin
                            state <= SMB_RD_ACK;
                            drive <= 1'b0;
                        end else if (sclFall) begin
                            shifter <= {shifter[6:0], 1'b0};
                            drive <= !shifter[6];
                        end
                    end
                    SMB_RD_ACK: begin
                        if (sclRise) begin
                            masterAck <= !sdaS2;
                            txReq <= !sdaS2;
                        end else if (sclFall) begin
                            bitCnt <= 4'h0;
                            state <= masterAck ? SMB_RD_BYTE : SMB_WAIT;
                            shifter <= txByte;
                            drive <= masterAck && !txByte[7];
                        end
                    end
                    default: begin
                        drive <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign sdaOut = 1'b0;
    assign sdaOeN = !drive; // Low while the client pulls data low

    // One byte stream to the register side, from the SMBus client or the SPI receiver; two-wire mode feeds none
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxValid <= 1'b0;
            rxBeat <= '0;
        end else begin
            rxValid <= smbValid || spiValid;
            if (smbValid) begin
                rxBeat <= '{first: smbFirst, data: smbData};
            end else if (spiValid) begin
                rxBeat <= '{first: spiFirstL, data: spiData};
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence rdAckFall;
        smbOn && state == SMB_RD_ACK && sclFall && !startCond && !stopCond;
    endsequence

    sequence addrReadFall;
        smbOn && state == SMB_ADDR_ACK && rw && sclFall && !startCond && !stopCond;
    endsequence

    chk_quiet_count: assert property ($rose(ready) |-> quietCnt == QW'(QUIET_CYCLES))
        else $error("ready rose before the quiet period elapsed");
    chk_quiet_silent: assert property (!ready |-> !rxValid && sdaOeN && state == SMB_IDLE)
        else $error("host activity answered during quiet period");
    chk_sel_held: assert property (captured && $past(captured) |-> $stable(sel))
        else $error("selection changed after capture");
    chk_spi_no_addr: assert property (captured && sel.mode != MODE_SMBUS |-> !sel.hasAddr)
        else $error("non-SMBus mode carries a slave address");
    chk_smb_addr_set: assert property (captured && sel.mode == MODE_SMBUS |->
            sel.hasAddr && sel.slaveAddr[6:3] == 4'h5 && sel.slaveAddr[2:0] <= 3'h4)
        else $error("SMBus address outside the strap set");
    chk_stop_idle: assert property (smbOn && stopCond |=> state == SMB_IDLE && sdaOeN)
        else $error("stop did not return client to idle");
    chk_write_ack: assert property (smbValid |-> drive ##1 !sdaOeN)
        else $error("written byte not acknowledged");
    chk_block_more: assert property (smbOn && state == SMB_WR_ACK && sclFall && !startCond
            && !stopCond |=> state == SMB_WR_BYTE && bitCnt == 4'h0)
        else $error("write did not continue to a further byte");
    chk_read_nack: assert property (rdAckFall and !masterAck |=> state == SMB_WAIT && sdaOeN)
        else $error("read continued after host nack");
    chk_read_load: assert property (addrReadFall |=>
            state == SMB_RD_BYTE && drive == !$past(txByte[7]))
        else $error("read data not loaded after address ack");
    chk_cs_ignored: assert property (spiEvent && !spiOn && !smbValid |=> !rxValid)
        else $error("SPI byte accepted outside SPI mode");
    chk_spi_stream: assert property (spiValid && !smbValid |=>
            rxValid && rxBeat.data == $past(spiData))
        else $error("SPI byte not forwarded");
    chk_two_wire_idle: assert property (sel.mode == MODE_TWO_WIRE |->
            !blockEnable && state == SMB_IDLE)
        else $error("two-wire mode left SMBus engine active");

endmodule
`default_nettype wire

// ==== verif/host_model.sv ====
// Host controller model driving the shared clock, data and select pins
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk,
    input wire logic sdaOut,
    input wire logic sdaOeN,
    output logic pinClk,
    output logic spiCsN,
    output logic spiMosi,
    output wire logic sdaLine
);
    logic hostSda = 1'b1;
    // Pulled-up open-drain data line, low while either party pulls it
    assign sdaLine = hostSda & (sdaOeN | sdaOut);
    initial begin
        pinClk = 1'b1;
        spiCsN = 1'b1;
        spiMosi = 1'b1;
    end
    // A quarter bit of the serial bus, in core clock cycles
    task automatic gap();
        repeat (10) @(negedge clk);
    endtask
    // Start or repeated start: data falls while the clock is high
    task automatic smbStart();
        gap();
        hostSda = 1'b1;
        gap();
        pinClk = 1'b1;
        gap();
        hostSda = 1'b0;
        gap();
        pinClk = 1'b0;
    endtask
    // Stop: data rises while the clock is high
    task automatic smbStop();
        gap();
        hostSda = 1'b0;
        gap();
        pinClk = 1'b1;
        gap();
        hostSda = 1'b1;
        gap();
    endtask
    // Nine clocks MSB first, data changed only while the clock is low
    task automatic smbXfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            gap();
            hostSda = tx[i];
            gap();
            pinClk = 1'b1;
            gap();
            rx[i] = sdaLine;
            gap();
            pinClk = 1'b0;
        end
    endtask
    // Select, then wait out the wake time before any clock edge
    task automatic spiSelect(input logic on);
        spiCsN = ~on;
        #12000;
    endtask
    // One 8-bit packet, MSB first, latched on the rising edge
    task automatic spiByte(input logic [7:0] b, input logic threeWire);
        for (int i = 7; i >= 0; i--) begin
            pinClk = 1'b0;
            if (threeWire) hostSda = b[i];
            else spiMosi = b[i];
            #24;
            pinClk = 1'b1;
            #24;
        end
        spiMosi = 1'b1;
        hostSda = 1'b1;
        #200;
    endtask
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the host interface select front end
`timescale 1ns/1ps
`default_nettype none
module tb;
    import host_select_pkg::*;
    localparam int QUIET = 16;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] strapCode = 3'h0;
    logic [7:0] txByte = 8'h00;
    logic pinClk, spiCsN, spiMosi, sdaOut, sdaOeN, txReq, ready, blockEnable, twoWireSel, rxValid;
    wire sdaLine;
    hostSel_t sel;
    byteBeat_t rxBeat;
    byteBeat_t beats[$];
    int failures = 0;
    int compares = 0;
    int reqs = 0;
    logic [7:0] readData [2] = '{8'hc3, 8'h3c};

    always #12.5 clk = ~clk;

    host_interface_select #(.QUIET_CYCLES(QUIET)) dut (.clk(clk), .rst_n(rst_n),
        .strapCode(strapCode), .spiClk(pinClk), .spiCsN(spiCsN), .spiMosi(spiMosi),
        .sclIn(pinClk), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .txByte(txByte),
        .txReq(txReq), .sel(sel), .ready(ready), .blockEnable(blockEnable),
        .twoWireSel(twoWireSel), .rxValid(rxValid), .rxBeat(rxBeat));
    host_model host (.clk(clk), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .pinClk(pinClk),
        .spiCsN(spiCsN), .spiMosi(spiMosi), .sdaLine(sdaLine));

    // Collect received bytes and answer read requests, away from the launching edge
    always @(negedge clk) begin
        if (rxValid === 1'b1) beats.push_back(rxBeat);
        if (txReq === 1'b1) begin
            txByte <= readData[reqs % 2];
            reqs++;
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Reset with a strap and wait out the quiet period, bounded
    task automatic startUp(input logic [2:0] code);
        int n;
        n = 0;
        @(negedge clk);
        strapCode = code;
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        while (ready !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        check(16'(n >= QUIET - 1 && n <= QUIET + 4), 16'h0001, "quiet period");
        if (n >= 200) complete_run();
        beats.delete();
        reqs = 0;
    endtask

    // Every strap code, its decode, and the hold after capture
    task automatic strapTable();
        hostMode_t modes [8] = '{MODE_SPI4, MODE_SPI3, MODE_TWO_WIRE, MODE_SMBUS,
            MODE_SMBUS, MODE_SMBUS, MODE_SMBUS, MODE_SMBUS};
        logic [6:0] addrs [8] = '{7'h00, 7'h00, 7'h00, 7'h2c, 7'h2b, 7'h2a, 7'h29, 7'h28};
        for (int c = 0; c < 8; c++) begin
            startUp(3'(c));
            check(16'(sel.hasAddr), 16'(c > 2), "address present");
            if (c > 2) check(16'(sel.slaveAddr), 16'(addrs[c]), "address");
            check(16'(blockEnable), 16'(c > 2), "block enable");
            check(16'(twoWireSel), 16'(c == 2), "two-wire enable");
            strapCode = ~strapCode;
            repeat (8) @(negedge clk);
            check(16'(sel.mode), 16'(modes[c]), "held mode");
        end
    endtask

    // Foreign address ignored, then a block write of three bytes
    task automatic smbWrite(input logic [2:0] code, input logic [6:0] addr);
        logic [8:0] rx;
        logic [7:0] data [3] = '{8'h5a, 8'ha5, 8'h01};
        startUp(code);
        host.spiSelect(1'b0);
        host.smbStart();
        host.smbXfer({addr ^ 7'h01, 1'b0, 1'b1}, rx);
        check(16'(rx[0]), 16'h0001, "foreign address answered");
        host.smbStop();
        host.smbStart();
        host.smbXfer({addr, 1'b0, 1'b1}, rx);
        check(16'(rx[0]), 16'h0000, "own address");
        for (int i = 0; i < 3; i++) begin
            host.smbXfer({data[i], 1'b1}, rx);
            check(16'(rx[0]), 16'h0000, "data acknowledge");
        end
        host.smbStop();
        check(16'(beats.size()), 16'h0003, "bytes received");
        for (int i = 0; i < beats.size() && i < 3; i++)
            check(16'(beats[i]), 16'({i == 0, data[i]}), "byte and flag");
    endtask

    // Pointer write, repeated start, two reads ending with a refusal
    task automatic smbRead();
        logic [8:0] rx;
        startUp(3'h4);
        host.spiSelect(1'b1);
        host.smbStart();
        host.smbXfer({7'h2b, 1'b0, 1'b1}, rx);
        host.smbXfer({8'h10, 1'b1}, rx);
        host.smbStart();
        host.smbXfer({7'h2b, 1'b1, 1'b1}, rx);
        check(16'(rx[0]), 16'h0000, "read address");
        host.smbXfer({8'hff, 1'b0}, rx);
        check(16'(rx[8:1]), 16'h00c3, "first read byte");
        host.smbXfer({8'hff, 1'b1}, rx);
        check(16'(rx[8:1]), 16'h003c, "second read byte");
        host.smbStop();
        check(16'(reqs), 16'h0002, "read requests");
        check(16'(beats.size() == 1 && beats[0] === 9'h110), 16'h0001, "pointer");
    endtask

    // Two packets under chip select, then one with the select released
    task automatic spiTest(input logic [2:0] code, input logic three, input logic want);
        startUp(code);
        host.spiSelect(1'b1);
        host.spiByte(8'h96, three);
        host.spiByte(8'h4b, three);
        host.spiSelect(1'b0);
        host.spiByte(8'h33, three);
        repeat (20) @(negedge clk);
        check(16'(beats.size()), want ? 16'h0002 : 16'h0000, "packets");
        if (want) begin
            check(16'(beats[0]), 16'h0196, "first packet");
            check(16'(beats[1]), 16'h004b, "second packet");
        end
    endtask

    initial begin
        strapTable();
        smbWrite(3'h3, 7'h2c);
        smbWrite(3'h7, 7'h28);
        smbRead();
        spiTest(3'h0, 1'b0, 1'b1);
        spiTest(3'h1, 1'b1, 1'b1);
        spiTest(3'h2, 1'b0, 1'b0);
        complete_run();
    end
endmodule
`default_nettype wire
